//--- logic/spictl_pkg.sv
// Shared constants, register layouts and offsets of the serial port block
package spictl_pkg;

    // ****************************************************************
    // Register bus geometry and register indices
    // ****************************************************************
    localparam int         ADDR_W    = 3;     // Register index width
    localparam logic [2:0] IDX_CTL1  = 3'h0;  // port_control_one
    localparam logic [2:0] IDX_CTL2  = 3'h1;  // port_control_two
    localparam logic [2:0] IDX_DIV   = 3'h2;  // clock_divider
    localparam logic [2:0] IDX_FLAGS = 3'h3;  // port_flags, read only
    localparam logic [2:0] IDX_CMP   = 3'h4;  // compare_value
    localparam logic [2:0] IDX_DATA  = 3'h5;  // shift_data_buffer

    // ****************************************************************
    // Field layouts, most significant field first
    // ****************************************************************
    typedef struct packed {
        logic rx_fault_irq_enable;  // Receive-full and fault interrupt gate
        logic port_enable;          // Whole port on
        logic tx_empty_irq_enable;  // Transmit-empty interrupt gate
        logic master_select;        // Port drives the serial clock
        logic clock_polarity;       // Idle level of the serial clock
        logic clock_phase;          // First edge at start of first bit
        logic select_output_enable; // Select pin driven by master
        logic low_bit_first;        // Least significant bit first
    } spictl_c1_t;

    typedef struct packed {
        logic       match_irq_enable;     // Match interrupt gate
        logic [1:0] rsv_hi;               // Unimplemented and reserved
        logic       fault_detect_enable;  // Mode fault detection on
        logic       bidir_output_enable;  // Single data pin drives
        logic       rsv_2;                // Reserved
        logic       halt_in_wait;         // Stop clocks in wait mode
        logic       single_wire_select;   // One shared data pin
    } spictl_c2_t;

    typedef struct packed {
        logic       rsv_7;     // Reserved
        logic [2:0] prescale;  // Prescale divisor is code plus one
        logic [3:0] rate;      // Rate divisor is two to the code plus one
    } spictl_div_t;

    // ****************************************************************
    // Reset values, write masks, fixed flag bits and limits
    // ****************************************************************
    localparam logic [7:0] C1_RST   = 8'h04;  // Slave, phase one, off
    localparam logic [7:0] C2_RST   = 8'h00;
    localparam logic [7:0] C2_MASK  = 8'h9b;  // Writable bits only
    localparam logic [7:0] DIV_RST  = 8'h00;
    localparam logic [7:0] DIV_MASK = 8'h7f;
    localparam logic [7:0] CMP_RST  = 8'h00;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [3:0] FLAG_RSV = 4'h0;   // Low status bits
    localparam logic [3:0] EDGE_LAST = 4'hf;  // Sixteen edges per byte
    localparam int         DIV_W_MIN = 19;    // Holds eight shl fifteen

endpackage

//--- logic/spictl_top.sv
// Byte-wide serial port with control, divider, flag, match and data registers
// How it works
// - Control one top bits: interrupts, enable, master
// - Polarity bit cleared gives idle-low clock
// - Phase bit set: edge at bit start
// - Select output bit with fault enable sets select use
// - Bit order cleared means most significant first
// - Control two top bit gates match interrupt
// - Fault detect enable cleared means no faults
// - Bidir output bit drives single data pin
// - Halt bit stops master clocks in wait
// - Pin select cleared uses separate data pins
// - Prescale code zero divides by one
// - Rate code zero divides by two
// - Receive-full flag marks new received byte
// - Match flag when received byte equals compare
// - Transmit-empty flag when shifter takes buffered byte
// - Fault flag applies only to master
// - Compare register holds eight-bit match value
// - Data write loads transmit, read returns receive
// - Status read then control write clears fault
// - Flag with its enable raises interrupt request while port enabled
// - Byte dropped while receive-full still set
// - Fault aborts transfer and clears master select
module spictl_top #(
    parameter int DIV_W = 20  // Width of the half-period counter
) (
    input  wire logic                          clk,
    input  wire logic                          rst_n,
    input  wire logic [spictl_pkg::ADDR_W-1:0] addr,
    input  wire logic [7:0]                    wdata,
    input  wire logic                          wr_en,
    input  wire logic                          rd_en,
    output logic      [7:0]                    rdata,
    input  wire logic                          cpu_wait,
    input  wire logic                          sclk_i,
    output logic                               sclk_o,
    output logic                               sclk_oe_n,
    input  wire logic                          mosi_i,
    output logic                               mosi_o,
    output logic                               mosi_oe_n,
    input  wire logic                          miso_i,
    output logic                               miso_o,
    output logic                               miso_oe_n,
    input  wire logic                          ss_n_i,
    output logic                               ss_n_o,
    output logic                               ss_n_oe_n,
    output logic                               irq
);

    // Counter must hold the slowest half period
    if (DIV_W < spictl_pkg::DIV_W_MIN)
    begin : g_chk
        $error("DIV_W too small for the slowest divider setting");
    end

    // ****************************************************************
    // Reset release
    // ****************************************************************
    logic rs1_ff;   // First release stage
    logic rs_n_ff;  // Released reset used everywhere else

    // Assert at once, release after two edges
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rs1_ff  <= 1'b0;
            rs_n_ff <= 1'b0;
        end
        else
        begin
            rs1_ff  <= 1'b1;
            rs_n_ff <= rs1_ff;
        end
    end

    // ****************************************************************
    // State
    // ****************************************************************
    spictl_pkg::spictl_c1_t  c1_ff;    // port_control_one
    spictl_pkg::spictl_c2_t  c2_ff;    // port_control_two
    spictl_pkg::spictl_div_t div_ff;   // clock_divider
    logic [7:0]        cmp_ff;         // compare_value
    logic [7:0]        txb_ff;         // Transmit buffer
    logic [7:0]        rxb_ff;         // Receive buffer
    logic              rxf_ff;         // rx_full_flag
    logic              mf_ff;          // match_flag
    logic              txe_ff;         // tx_empty_flag
    logic              flt_ff;         // fault_flag
    logic              arm_rx_ff;      // Status seen with receive-full set
    logic              arm_tx_ff;      // Status seen with transmit-empty set
    logic              arm_flt_ff;     // Status seen with fault set
    logic              busy_ff;        // Byte in flight
    logic [3:0]        edge_ff;        // Serial clock edge index
    logic [7:0]        sr_ff;          // Shift register, send bit on top
    logic              inbit_ff;       // Bit caught on the sample edge
    logic [DIV_W-1:0]  cnt_ff;         // Half-period counter
    logic              sclk_ff;        // Master clock level
    logic              sprev_ff;       // Last sampled slave clock
    logic [7:0]        rdata_ff;       // Read answer
    logic              irq_ff;         // Interrupt request
    logic              mosi_ff;        // Registered pin levels
    logic              mosi_oe_n_ff;
    logic              miso_ff;
    logic              miso_oe_n_ff;
    logic              sclk_oe_n_ff;
    logic              ss_ff;
    logic              ss_oe_n_ff;

    // Mirror order so the shift register always runs top bit first
    function automatic logic [7:0] spictl_rev(input logic [7:0] v);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < 8; i++)
        begin
            r[i] = v[7 - i];
        end
        return r;
    endfunction

    // ****************************************************************
    // Decode
    // ****************************************************************
    wire sel_c1  = (addr == spictl_pkg::IDX_CTL1);
    wire sel_c2  = (addr == spictl_pkg::IDX_CTL2);
    wire sel_div = (addr == spictl_pkg::IDX_DIV);
    wire sel_flg = (addr == spictl_pkg::IDX_FLAGS);
    wire sel_cmp = (addr == spictl_pkg::IDX_CMP);
    wire sel_dat = (addr == spictl_pkg::IDX_DATA);
    wire wr_c1   = wr_en & sel_c1;
    wire wr_d    = wr_en & sel_dat;
    wire rd_s    = rd_en & sel_flg;
    wire rd_d    = rd_en & sel_dat;
    wire [7:0] flags_rd = {rxf_ff, mf_ff, txe_ff, flt_ff, spictl_pkg::FLAG_RSV};
    wire [7:0] rd_mux = sel_c1  ? c1_ff :
                        sel_c2  ? (c2_ff & spictl_pkg::C2_MASK) :
                        sel_div ? (div_ff & spictl_pkg::DIV_MASK) :
                        sel_flg ? flags_rd :
                        sel_cmp ? cmp_ff :
                        sel_dat ? rxb_ff : 8'h00;

    // ****************************************************************
    // Mode and engine control
    // ****************************************************************
    wire is_mst = c1_ff.port_enable & c1_ff.master_select;
    wire is_slv = c1_ff.port_enable & ~c1_ff.master_select & ~ss_n_i;
    wire ss_in  = c2_ff.fault_detect_enable & ~c1_ff.select_output_enable;
    wire fault  = is_mst & ss_in & ~ss_n_i;
    wire halt   = c2_ff.halt_in_wait & cpu_wait;
    // half period is prescale plus one, shl rate
    wire [DIV_W-1:0] half = ({{(DIV_W-3){1'b0}}, div_ff.prescale} + 1'b1)
                            << div_ff.rate;
    wire [DIV_W-1:0] cnt_top = half - 1'b1;
    wire m_tick  = is_mst & busy_ff & ~halt & (cnt_ff == cnt_top);
    wire s_edge  = is_slv & busy_ff & (sclk_i != sprev_ff);
    wire edge_ev = m_tick | s_edge;
    wire last    = edge_ev & (edge_ff == spictl_pkg::EDGE_LAST);
    wire samp    = edge_ev & (edge_ff[0] == c1_ff.clock_phase);
    wire shft    = edge_ev & ~samp & (edge_ff != 4'h0);
    wire din     = c2_ff.single_wire_select ? (is_mst ? mosi_i : miso_i)
                                            : (is_mst ? miso_i : mosi_i);
    wire nbit    = (last & c1_ff.clock_phase) ? din : inbit_ff;
    wire [7:0] sr_sh = {sr_ff[6:0], nbit};
    wire [7:0] rx_byte = c1_ff.low_bit_first ? spictl_rev(sr_sh) : sr_sh;
    wire [7:0] tx_load = c1_ff.low_bit_first ? spictl_rev(txb_ff) : txb_ff;
    wire start_m = is_mst & ~busy_ff & ~txe_ff & ~fault;
    wire start_s = is_slv & ~busy_ff;
    wire start   = start_m | start_s;
    wire accept  = last & ~rxf_ff;
    wire abort   = ~c1_ff.port_enable | fault | (~is_mst & ~is_slv);
    wire nxt_out = start ? tx_load[7] : (shft ? sr_sh[7] : sr_ff[7]);  // Moves on launch edges

    // ****************************************************************
    // Flag next values, set wins over clear
    // ****************************************************************
    wire nxt_rxf = accept | (rxf_ff & ~(rd_d & arm_rx_ff));
    wire nxt_mf  = (accept & (rx_byte == cmp_ff)) | (mf_ff & ~(rd_d & arm_rx_ff));
    wire nxt_txe = (start & ~txe_ff) | (txe_ff & ~(wr_d & arm_tx_ff));
    wire nxt_flt = fault | (flt_ff & ~(wr_c1 & arm_flt_ff));
    wire nxt_irq = c1_ff.port_enable &
                   ((c1_ff.rx_fault_irq_enable & (rxf_ff | flt_ff)) |
                    (c1_ff.tx_empty_irq_enable & txe_ff) |
                    (c2_ff.match_irq_enable & mf_ff));

    // ****************************************************************
    // Register file
    // ****************************************************************
    // Software writes; the fault forces master select low
    always_ff @(posedge clk or negedge rs_n_ff)
    begin
        if (!rs_n_ff)
        begin
            c1_ff  <= spictl_pkg::C1_RST;
            c2_ff  <= spictl_pkg::C2_RST;
            div_ff <= spictl_pkg::DIV_RST;
            cmp_ff <= spictl_pkg::CMP_RST;
            txb_ff <= spictl_pkg::BYTE_RST;
        end
        else
        begin
            if (wr_c1)
                c1_ff <= wdata;
            if (fault)
                c1_ff.master_select <= 1'b0;
            if (wr_en & sel_c2)
                c2_ff <= wdata & spictl_pkg::C2_MASK;
            if (wr_en & sel_div)
                div_ff <= wdata & spictl_pkg::DIV_MASK;
            if (wr_en & sel_cmp)
                cmp_ff <= wdata;
            if (wr_d)
                txb_ff <= wdata;
        end
    end

    // Flags, arming reads and the read answer
    always_ff @(posedge clk or negedge rs_n_ff)
    begin
        if (!rs_n_ff)
        begin
            rxf_ff     <= 1'b0;
            mf_ff      <= 1'b0;
            txe_ff     <= 1'b1;
            flt_ff     <= 1'b0;
            arm_rx_ff  <= 1'b0;
            arm_tx_ff  <= 1'b0;
            arm_flt_ff <= 1'b0;
            rxb_ff     <= spictl_pkg::BYTE_RST;
            rdata_ff   <= 8'h00;
            irq_ff     <= 1'b0;
        end
        else
        begin
            rxf_ff     <= nxt_rxf;
            mf_ff      <= nxt_mf;
            txe_ff     <= nxt_txe;
            flt_ff     <= nxt_flt;
            arm_rx_ff  <= (rd_s & rxf_ff) | (arm_rx_ff & nxt_rxf);
            arm_tx_ff  <= (rd_s & txe_ff) | (arm_tx_ff & nxt_txe);
            arm_flt_ff <= (rd_s & flt_ff) | (arm_flt_ff & nxt_flt);
            if (accept)
                rxb_ff <= rx_byte;
            rdata_ff   <= rd_en ? rd_mux : 8'h00;
            irq_ff     <= nxt_irq;
        end
    end

    // ****************************************************************
    // Shift engine
    // ****************************************************************
    // sixteen edges, eight bits
    always_ff @(posedge clk or negedge rs_n_ff)
    begin
        if (!rs_n_ff)
        begin
            busy_ff  <= 1'b0;
            edge_ff  <= 4'h0;
            sr_ff    <= spictl_pkg::BYTE_RST;
            inbit_ff <= 1'b0;
            cnt_ff   <= '0;
        end
        else if (abort)
        begin
            busy_ff <= 1'b0;
            edge_ff <= 4'h0;
        end
        else if (start)
        begin
            busy_ff <= 1'b1;
            edge_ff <= 4'h0;
            sr_ff   <= tx_load;
            // Phase one fires the first edge on the next cycle
            cnt_ff  <= c1_ff.clock_phase ? cnt_top : '0;
        end
        else if (busy_ff)
        begin
            if (is_mst & ~halt)
                cnt_ff <= m_tick ? '0 : cnt_ff + 1'b1;
            if (edge_ev)
                edge_ff <= edge_ff + 4'h1;
            if (samp)
                inbit_ff <= din;
            if (shft | last)
                sr_ff <= sr_sh;
            if (last)
                busy_ff <= 1'b0;
        end
    end

    // ****************************************************************
    // Pin drivers, all registered
    // ****************************************************************
    // Master clock idles at polarity and toggles per tick
    always_ff @(posedge clk or negedge rs_n_ff)
    begin
        if (!rs_n_ff)
        begin
            sclk_ff      <= 1'b0;
            sprev_ff     <= 1'b0;
            sclk_oe_n_ff <= 1'b1;
            mosi_ff      <= 1'b0;
            mosi_oe_n_ff <= 1'b1;
            miso_ff      <= 1'b0;
            miso_oe_n_ff <= 1'b1;
            ss_ff        <= 1'b1;
            ss_oe_n_ff   <= 1'b1;
        end
        else
        begin
            sclk_ff      <= (is_mst & busy_ff & ~start) ? (sclk_ff ^ m_tick)
                                                        : c1_ff.clock_polarity;
            sprev_ff     <= (start_s | ~busy_ff) ? c1_ff.clock_polarity : sclk_i;
            sclk_oe_n_ff <= ~is_mst;
            mosi_ff      <= last ? mosi_ff : nxt_out;
            miso_ff      <= last ? miso_ff : nxt_out;
            mosi_oe_n_ff <= ~(is_mst & ~fault &
                              (~c2_ff.single_wire_select | c2_ff.bidir_output_enable));
            miso_oe_n_ff <= ~(is_slv &
                              (~c2_ff.single_wire_select | c2_ff.bidir_output_enable));
            ss_oe_n_ff   <= ~(is_mst & c2_ff.fault_detect_enable &
                              c1_ff.select_output_enable);
            ss_ff        <= ~(busy_ff | start_m);
        end
    end

    assign rdata     = rdata_ff;
    assign irq       = irq_ff;
    assign sclk_o    = sclk_ff;
    assign sclk_oe_n = sclk_oe_n_ff;
    assign mosi_o    = mosi_ff;
    assign mosi_oe_n = mosi_oe_n_ff;
    assign miso_o    = miso_ff;
    assign miso_oe_n = miso_oe_n_ff;
    assign ss_n_o    = ss_ff;
    assign ss_n_oe_n = ss_oe_n_ff;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rs_n_ff);

    AST_FAULT_ABORT: assert property (
        fault |=> !c1_ff.master_select && !busy_ff && flt_ff)
        else $error("Fault did not abort and drop master");
    AST_NO_FAULT_OFF: assert property (
        !c2_ff.fault_detect_enable |=> !$rose(flt_ff))
        else $error("Fault raised with detection off");
    AST_OVERRUN_KEEP: assert property (
        last && rxf_ff |=> $stable(rxb_ff))
        else $error("Receive buffer overwritten while full");
    AST_RX_LAND: assert property (
        accept |=> rxf_ff && rxb_ff == $past(rx_byte))
        else $error("Received byte not stored with flag");
    AST_MATCH_EQ: assert property (
        $rose(mf_ff) |-> rxb_ff == $past(cmp_ff))
        else $error("Match flag without equal byte");
    AST_TXE_CLEAR: assert property (
        wr_d && arm_tx_ff && txe_ff |=> !txe_ff ##1 !txe_ff || busy_ff)
        else $error("Transmit empty not cleared by write");
    AST_FAST_TICK: assert property (
        is_mst && busy_ff && !halt && div_ff == 8'h00 && !$rose(busy_ff)
        |-> m_tick)
        else $error("Divide by two does not tick every cycle");
    AST_IDLE_POL: assert property (
        is_mst && !busy_ff && $stable(c1_ff) |=> sclk_o == $past(c1_ff.clock_polarity))
        else $error("Serial clock not at idle level");
    AST_FLT_CLEAR: assert property (
        wr_c1 && arm_flt_ff && !fault |=> !flt_ff)
        else $error("Fault flag not cleared");
    AST_IRQ_OFF: assert property (
        !c1_ff.port_enable |=> !irq)
        else $error("Interrupt while port disabled");
    AST_HALT_FREEZE: assert property (
        halt && is_mst && busy_ff && !abort |=> $stable(edge_ff) && $stable(sr_ff))
        else $error("Master advanced while halted");

    COV_MASTER_BYTE: cover property (is_mst && last);
    COV_SLAVE_BYTE:  cover property (is_slv && last);
    COV_OVERRUN:     cover property (last && rxf_ff);
    COV_FAULT:       cover property (fault);

endmodule

//--- tb/spictl_peer.sv
// Serial peripheral model answering the port while the port is master
module spictl_peer (
    input  wire logic       sclk,     // Serial clock from the port
    input  wire logic       mosi,     // Data from the port
    input  wire logic       lsb,      // Low bit first when set
    input  wire logic [7:0] tx_byte,  // Byte this peer sends back
    output logic            miso,     // Data to the port
    output logic      [7:0] rx_byte   // Last whole byte received
);
    timeunit 1ns;
    timeprecision 1ns;
    int         cnt = 0;      // Bits done in this frame
    logic [7:0] sh  = 8'h00;  // Incoming shift
    logic       armed = 1'b0; // Reset takes the clock from unknown to low: not a bit
    initial miso = 1'b0;
    always @(posedge sclk)
    begin
        armed = 1'b1;
        miso <= lsb ? tx_byte[cnt] : tx_byte[7 - cnt];
    end
    always @(negedge sclk)
    begin
        if (armed)
        begin
            sh = lsb ? {mosi, sh[7:1]} : {sh[6:0], mosi};
            cnt = (cnt + 1) % 8;
            if (cnt == 0)
            begin
                rx_byte = sh;
                // Released line shows the inverse, never a stale copy
                miso <= ~miso;
            end
        end
    end
endmodule

//--- tb/tb_top.sv
// Self-checking bench for the serial port registers and master transfers
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    // ****************************************************************
    // Stimulus and observation signals
    // ****************************************************************
    logic       clk = 1'b0, rst_n = 1'b0, wr_en = 1'b0, rd_en = 1'b0;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00, rdata, ptx = 8'h00, prx, d, f, v, cm;
    logic       sclk, mosi, miso, irq, lsb = 1'b0, full;
    logic       sclk_oe_n, mosi_oe_n, miso_o, miso_oe_n, ss_n_o, ss_n_oe_n;
    logic       ss_n = 1'b1, cpu_wait = 1'b0;  // Select and wait-mode inputs
    logic [31:0] seed = 32'd69709;  // Fixed seed keeps runs repeatable
    int         n_fail = 0, samples_checked = 0, i, k;
    logic [7:0] rv [7] = '{8'h04, 8'h00, 8'h00, 8'h20, 8'h00, 8'h00, 8'h00};

    always #5 clk = ~clk;

    spictl_top uut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
        .rd_en(rd_en), .rdata(rdata), .cpu_wait(cpu_wait), .sclk_i(1'b0), .sclk_o(sclk),
        .sclk_oe_n(sclk_oe_n), .mosi_i(1'b0), .mosi_o(mosi), .mosi_oe_n(mosi_oe_n),
        .miso_i(miso), .miso_o(miso_o), .miso_oe_n(miso_oe_n), .ss_n_i(ss_n), .ss_n_o(ss_n_o),
        .ss_n_oe_n(ss_n_oe_n), .irq(irq));
    spictl_peer peer (.sclk(sclk), .mosi(mosi), .lsb(lsb), .tx_byte(ptx), .miso(miso),
        .rx_byte(prx));

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [7:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Bus cycles: one-cycle strobes, read data taken in the following cycle
    task automatic wr(input logic [2:0] a, input logic [7:0] x);
        @(posedge clk);
        addr <= a; wdata <= x; wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] x);
        @(posedge clk);
        addr <= a; rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 x = rdata;
    endtask
    // Poll flags until a byte arrives; bounded so a hang ends the run
    task automatic wait_full();
        full = 1'b0;
        for (i = 0; i < 200 && !full; i++)
        begin
            rd(spictl_pkg::IDX_FLAGS, f);
            full = f[7];
        end
        if (!full)
        begin
            n_fail++;
            tally_and_finish();
        end
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial
    begin
        repeat (16) @(posedge clk);
        v = {sclk, mosi, miso_o, irq, sclk_oe_n, mosi_oe_n, miso_oe_n, ss_n_oe_n};
        check("reset pins", v, 8'h0f);
        check("reset rdata", rdata, 8'h00);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        for (k = 0; k < 7; k++)
        begin
            rd(k[2:0], v);
            check("reset value", v, rv[k]);
        end
        wr(spictl_pkg::IDX_CTL2, 8'hff);
        rd(spictl_pkg::IDX_CTL2, v);
        check("ctl2 mask", v, 8'h9b);
        wr(spictl_pkg::IDX_DIV, 8'hff);
        rd(spictl_pkg::IDX_DIV, v);
        check("div mask", v, 8'h7f);
        wr(3'h6, 8'h55);
        rd(3'h6, v);
        check("unmapped", v, 8'h00);
        wr(spictl_pkg::IDX_DIV, 8'h00);
        wr(spictl_pkg::IDX_CTL2, 8'h80);
        // Transfers at the fastest rate except one at prescale and rate code one, both bit orders, match on and off
        for (k = 0; k < 6; k++)
        begin
            lsb = k[0];
            wr(spictl_pkg::IDX_CTL1, {7'h2a, lsb});
            wr(spictl_pkg::IDX_DIV, (k == 4) ? 8'h11 : 8'h00);
            ptx = (k == 0) ? 8'h00 : rnd();
            d = (k == 1) ? 8'hff : rnd();
            cm = (k % 3 == 0) ? ptx : ~ptx;
            wr(spictl_pkg::IDX_CMP, cm);
            rd(spictl_pkg::IDX_FLAGS, f);
            check("tx empty", {7'h0, f[5]}, 8'h01);
            wr(spictl_pkg::IDX_DATA, d);
            wait_full();
            check("match flag", {7'h0, f[6]}, {7'h0, cm == ptx});
            repeat (2) @(posedge clk);
            check("irq", {7'h0, irq}, {7'h0, cm == ptx});
            check("peer got", prx, d);
            rd(spictl_pkg::IDX_DATA, v);
            check("rx data", v, ptx);
            rd(spictl_pkg::IDX_FLAGS, f);
            check("flags clear", f & 8'hc0, 8'h00);
            v = {sclk, sclk_oe_n, mosi_oe_n, miso_oe_n, ss_n_o, ss_n_oe_n, 2'b00};
            check("pins idle", v, 8'h1c);
        end
        // Select pulled low under a master with fault detection on
        wr(spictl_pkg::IDX_CTL2, 8'h90);
        @(posedge clk);
        ss_n <= 1'b0;
        repeat (2) @(posedge clk);
        ss_n <= 1'b1;
        rd(spictl_pkg::IDX_FLAGS, f);
        check("fault flag", f & 8'h10, 8'h10);
        rd(spictl_pkg::IDX_CTL1, v);
        check("master dropped", v, {7'h22, lsb});
        wr(spictl_pkg::IDX_CTL1, {7'h2a, lsb});
        rd(spictl_pkg::IDX_FLAGS, f);
        check("fault cleared", f & 8'h10, 8'h00);
        // Wait mode with halt set freezes the master, release finishes it
        ptx = 8'h3c;
        wr(spictl_pkg::IDX_CTL2, 8'h82);
        cpu_wait <= 1'b1;
        wr(spictl_pkg::IDX_DATA, rnd());
        repeat (30) @(posedge clk);
        rd(spictl_pkg::IDX_FLAGS, f);
        check("halted", f & 8'h80, 8'h00);
        @(posedge clk);
        cpu_wait <= 1'b0;
        // A second byte ending while the first is unread is dropped
        wait_full();
        ptx = 8'hc3;
        wr(spictl_pkg::IDX_DATA, rnd());
        repeat (40) @(posedge clk);
        rd(spictl_pkg::IDX_DATA, v);
        check("kept byte", v, 8'h3c);
        tally_and_finish();
    end
endmodule
